// ===== verilog/input_capture_channels.sv
/*
 Eight-channel input capture unit with Avalon-MM register slave,
 per-channel interrupt flags and enables, and a wake request.
 Assumes timer counts, pins and CPU power states sync to mclk_i.
*/
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
// What this block does
// - Eight independent capture channels
// - Mode field selects edge type and prescale
// - Prescaler cleared when off or reset
// - Four-entry sixteen-bit FIFO per channel
// - Not-empty flag until all entries read
// - Read returns oldest, rest move forward
// - Fifth capture when full sets overflow
// - After overflow ignore captures until emptied
// - Bit seven selects timer, default third
// - Every-edge mode interrupts on each edge
// - Every-edge mode never flags overflow
// - Wake mode with enable wakes the CPU
// - Sleep: wake mode rising-edge interrupt only
// - Idle: full function unless halted
// - Wake mode in idle stores nothing
// - Two-bit field sets events per interrupt
// - Per-channel flag gated by enable bit
`timescale 1ns/1ps
`default_nettype none

module input_capture_channels (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // Avalon-MM slave
   input wire logic [6:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Capture pins and time bases
   input wire logic [7:0] capture_pin_i,
   input wire logic [15:0] timer2_i,
   input wire logic [15:0] timer3_i,
   // CPU power state
   input wire logic sleep_i,
   input wire logic idle_i,
   // Interrupt and wake requests
   output logic [7:0] channel_irq_req_o,
   output logic wake_o
);
   // ==========================================================
   // Bus handshake
   // Every access waits one cycle so read data come from a flop
   wire req = avs_read_i | avs_write_i;
   wire done = req & ~avs_waitrequest_o;
   wire wr = avs_write_i & done;
   wire rd = avs_read_i & done;

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_waitrequest_o <= ~(req & avs_waitrequest_o);
      end
   end

   // ==========================================================
   // Address decode
   wire in_ch = ~avs_address_i[icap_pkg::REGION_BIT] & (avs_address_i[1:0] == 2'h0);
   wire [2:0] ch_idx = avs_address_i[icap_pkg::CH_LSB +: 3];
   wire is_ctrl = avs_address_i[icap_pkg::CTRL_SEL_BIT];
   wire hit_flag = avs_address_i == icap_pkg::FLAG_ADDR;
   wire hit_en = avs_address_i == icap_pkg::EN_ADDR;
   wire [15:0] be_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   wire [15:0] wdata = avs_writedata_i[15:0];

   // ==========================================================
   // Channels
   logic [15:0] ctrl [icap_pkg::NUM_CH];
   logic [15:0] ctrl_rd [icap_pkg::NUM_CH];
   logic [15:0] head [icap_pkg::NUM_CH];
   logic [7:0] has_data;
   logic [7:0] ovf;
   logic [7:0] irq_set;
   logic [7:0] pop;
   logic [7:0] wake_mode;
   logic [7:0] flags;
   logic [7:0] irq_en;

   genvar g;
   generate
      for (g = 0; g < icap_pkg::NUM_CH; g++) begin : gen_ch
         wire ctrl_wr = wr & in_ch & is_ctrl & (ch_idx == 3'(g));
         assign pop[g] = rd & in_ch & ~is_ctrl & (ch_idx == 3'(g));
         assign wake_mode[g] = ctrl[g][2:0] == icap_pkg::MODE_WAKE;

         always_ff @(posedge mclk_i) begin
            if (reset_i) begin
               ctrl[g] <= icap_pkg::CTRL_RESET;
            end else if (ctrl_wr) begin
               ctrl[g] <= (ctrl[g] & ~be_mask) | (wdata & be_mask & icap_pkg::CTRL_WMASK);
            end
         end

         // Status bits are live views, never stored
         assign ctrl_rd[g] = {ctrl[g][15:icap_pkg::OVF_BIT + 1], ovf[g], has_data[g],
                              ctrl[g][icap_pkg::HAS_DATA_BIT - 1:0]};

         capture_channel u_ch (
            .mclk_i(mclk_i),
            .reset_i(reset_i),
            .pin_i(capture_pin_i[g]),
            .timer2_i(timer2_i),
            .timer3_i(timer3_i),
            .mode_i(ctrl[g][icap_pkg::MODE_LSB +: 3]),
            .epi_i(ctrl[g][icap_pkg::EPI_LSB +: 2]),
            .tsel_i(ctrl[g][icap_pkg::TSEL_BIT]),
            .halt_i(ctrl[g][icap_pkg::HALT_BIT]),
            .sleep_i(sleep_i),
            .idle_i(idle_i),
            .pop_i(pop[g]),
            .head_o(head[g]),
            .has_data_o(has_data[g]),
            .ovf_o(ovf[g]),
            .irq_set_o(irq_set[g])
         );

         property p_flag_set;
            @(posedge mclk_i) disable iff (reset_i)
            irq_set[g] |=> flags[g];
         endproperty
         a_flag_set: assert property (p_flag_set) else $error("flag missed its event");

         property p_ne;
            @(posedge mclk_i) disable iff (reset_i)
            !has_data[g] && $past(ctrl[g][2:0]) == ctrl[g][2:0] ##1 has_data[g] |-> !ovf[g];
         endproperty
         a_ne: assert property (p_ne) else $error("first capture found overflow");

         property p_pre_off;
            @(posedge mclk_i) disable iff (reset_i)
            ctrl[g][2:0] == icap_pkg::MODE_OFF |=> !irq_set[g] && gen_ch[g].u_ch.pre == 4'h0;
         endproperty
         a_pre_off: assert property (p_pre_off) else $error("off channel still active");

         property p_no_ovf_both;
            @(posedge mclk_i) disable iff (reset_i)
            ctrl[g][2:0] == icap_pkg::MODE_BOTH |=> !$rose(ovf[g]);
         endproperty
         a_no_ovf_both: assert property (p_no_ovf_both) else $error("overflow in every-edge mode");

         property p_off_store;
            @(posedge mclk_i) disable iff (reset_i)
            ctrl[g][2:0] == icap_pkg::MODE_OFF |=> !$rose(has_data[g]);
         endproperty
         a_off_store: assert property (p_off_store) else $error("off channel stored a capture");
      end
   endgenerate

   // ==========================================================
   // Read path
   wire [15:0] ch_word = is_ctrl ? ctrl_rd[ch_idx] : head[ch_idx];
   // Unmapped addresses read as zero and ignore writes
   wire [31:0] rd_mux = in_ch ? {16'h0000, ch_word} :
                        hit_flag ? {24'h000000, flags} :
                        hit_en ? {24'h000000, irq_en} : 32'h00000000;

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         avs_readdata_o <= 32'h00000000;
      end else if (req && avs_waitrequest_o) begin
         avs_readdata_o <= rd_mux;
      end
   end

   // ==========================================================
   // Interrupt flags and enables
   // Flags clear by writing one; a same-cycle event wins
   wire [7:0] flag_clr = (wr && hit_flag && avs_byteenable_i[0]) ? wdata[7:0] : 8'h00;

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         flags <= 8'h00;
         irq_en <= 8'h00;
      end else begin
         flags <= irq_set | (flags & ~flag_clr);
         if (wr && hit_en && avs_byteenable_i[0]) begin
            irq_en <= wdata[7:0];
         end
      end
   end

   // ==========================================================
   // Interrupt and wake outputs
   wire low_power = sleep_i | idle_i;
   wire wake_hit = |(irq_set & irq_en & wake_mode);

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         channel_irq_req_o <= 8'h00;
         wake_o <= 1'b0;
      end else begin
         channel_irq_req_o <= flags & irq_en;
         wake_o <= low_power & wake_hit;
      end
   end

   // ==========================================================
   // Checks
   property p_gate;
      @(posedge mclk_i) disable iff (reset_i)
      flags[0] && !irq_en[0] |=> !channel_irq_req_o[0];
   endproperty
   a_gate: assert property (p_gate) else $error("disabled flag reached output");

   property p_irq_path;
      @(posedge mclk_i) disable iff (reset_i)
      irq_set[5] && irq_en[5] ##1 irq_en[5] |=> channel_irq_req_o[5];
   endproperty
   a_irq_path: assert property (p_irq_path) else $error("event gave no request");

   property p_wake;
      @(posedge mclk_i) disable iff (reset_i)
      sleep_i && irq_set[7] && irq_en[7] && wake_mode[7] |=> wake_o;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on capture event");

   property p_sleep_store;
      @(posedge mclk_i) disable iff (reset_i)
      sleep_i && !pop[6] |=> $stable(has_data[6]) || !has_data[6];
   endproperty
   a_sleep_store: assert property (p_sleep_store) else $error("capture stored in sleep");

   property p_idle_wake;
      @(posedge mclk_i) disable iff (reset_i)
      idle_i && wake_mode[7] && !pop[7] |=> !$rose(has_data[7]);
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("wake mode stored in idle");

   property p_wait;
      @(posedge mclk_i) disable iff (reset_i)
      req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
   endproperty
   a_wait: assert property (p_wait) else $error("bus answer not one cycle");

   property p_pop_single;
      @(posedge mclk_i) disable iff (reset_i)
      $onehot0(pop) && (pop == 8'h00 || rd);
   endproperty
   a_pop_single: assert property (p_pop_single) else $error("fifo popped without read");

   property p_wait_idle;
      @(posedge mclk_i) disable iff (reset_i)
      !req |=> avs_waitrequest_o;
   endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("wait state dropped without request");

   property p_rdata_hold;
      @(posedge mclk_i) disable iff (reset_i)
      !req |=> $stable(avs_readdata_o);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed while idle");

   property p_unmapped;
      @(posedge mclk_i) disable iff (reset_i)
      rd && !in_ch && !hit_flag && !hit_en |-> avs_readdata_o == 32'h00000000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   property p_en_write;
      @(posedge mclk_i) disable iff (reset_i)
      wr && hit_en && avs_byteenable_i[0] |=> irq_en == $past(wdata[7:0]);
   endproperty
   a_en_write: assert property (p_en_write) else $error("enable write lost");

   property p_ctrl_write;
      @(posedge mclk_i) disable iff (reset_i)
      wr && in_ch && is_ctrl && ch_idx == 3'h0 && avs_byteenable_i[1:0] == 2'h3 |=>
         ctrl[0] == $past(wdata & icap_pkg::CTRL_WMASK);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

   property p_flag_clear;
      @(posedge mclk_i) disable iff (reset_i)
      wr && hit_flag && avs_byteenable_i[0] && wdata[0] && !irq_set[0] |=> !flags[0];
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by write");

   property p_wake_low;
      @(posedge mclk_i) disable iff (reset_i)
      !low_power |=> !wake_o;
   endproperty
   a_wake_low: assert property (p_wake_low) else $error("wake raised while awake");

   property p_wake_en;
      @(posedge mclk_i) disable iff (reset_i)
      !(|(irq_en & wake_mode)) |=> !wake_o;
   endproperty
   a_wake_en: assert property (p_wake_en) else $error("wake without enabled wake channel");

   c_both: cover property (@(posedge mclk_i) disable iff (reset_i) irq_set[5] && ctrl[5][2:0] == icap_pkg::MODE_BOTH);
   c_overflow: cover property (@(posedge mclk_i) disable iff (reset_i) $rose(ovf[0]));
   c_wake: cover property (@(posedge mclk_i) disable iff (reset_i) $rose(wake_o));
   c_irq: cover property (@(posedge mclk_i) disable iff (reset_i) $rose(channel_irq_req_o[0]));
   c_pop: cover property (@(posedge mclk_i) disable iff (reset_i) pop[0] && has_data[0]);
endmodule : input_capture_channels

`default_nettype wire

// ===== verilog/icap_pkg.sv
/*
 Shared constants for the eight-channel input capture unit: sizes,
 control field positions, capture modes and the register map.
 Assumes a 32-bit Avalon-MM slave port with byte addresses.
*/
`default_nettype none

package icap_pkg;
   // ==========================================================
   // Sizes
   localparam int NUM_CH = 8;
   localparam int DATA_W = 16;
   localparam int DEPTH = 4;
   localparam int ADDR_W = 7;
   localparam logic [2:0] FULL_CNT = 3'h4;

   // ==========================================================
   // Control word fields
   localparam int MODE_LSB = 0;
   localparam int HAS_DATA_BIT = 3;
   localparam int OVF_BIT = 4;
   localparam int EPI_LSB = 5;
   localparam int TSEL_BIT = 7;
   localparam int HALT_BIT = 13;
   localparam logic [15:0] CTRL_WMASK = 16'h20E7;
   localparam logic [15:0] CTRL_RESET = 16'h0000;

   typedef enum logic [2:0] {
      MODE_OFF = 3'b000,
      MODE_BOTH = 3'b001,
      MODE_FALL = 3'b010,
      MODE_RISE = 3'b011,
      MODE_RISE4 = 3'b100,
      MODE_RISE16 = 3'b101,
      MODE_RSVD = 3'b110,
      MODE_WAKE = 3'b111
   } capture_mode_e;

   localparam logic [3:0] PRE4_LAST = 4'h3;
   localparam logic [3:0] PRE16_LAST = 4'hF;

   // ==========================================================
   // Register map
   localparam logic [ADDR_W-1:0] FLAG_ADDR = 7'h40;
   localparam logic [ADDR_W-1:0] EN_ADDR = 7'h44;
   localparam int REGION_BIT = 6;
   localparam int CH_LSB = 3;
   localparam int CTRL_SEL_BIT = 2;
endpackage : icap_pkg

`default_nettype wire

// ===== verilog/capture_channel.sv
/*
 One capture channel: pin synchroniser, edge select and prescale,
 four-word FIFO with overflow lock, interrupt event counter.
 Assumes the timers and the pin are synchronous to mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module capture_channel (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // Pin and timers
   input wire logic pin_i,
   input wire logic [15:0] timer2_i,
   input wire logic [15:0] timer3_i,
   // Configuration
   input wire logic [2:0] mode_i,
   input wire logic [1:0] epi_i,
   input wire logic tsel_i,
   input wire logic halt_i,
   input wire logic sleep_i,
   input wire logic idle_i,
   // FIFO read
   input wire logic pop_i,
   output logic [15:0] head_o,
   output logic has_data_o,
   output logic ovf_o,
   output logic irq_set_o
);
   // ==========================================================
   // Input sync and edges
   logic sync1, sync2, prev;
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         prev <= 1'b0;
      end else begin
         sync1 <= pin_i;
         sync2 <= sync1;
         prev <= sync2;
      end
   end
   wire rise = sync2 & ~prev;
   wire fall = ~sync2 & prev;

   // ==========================================================
   // Event select
   icap_pkg::capture_mode_e mode;
   assign mode = icap_pkg::capture_mode_e'(mode_i);
   logic [3:0] pre;
   logic [2:0] cnt;
   logic [1:0] ev_cnt;
   logic hit;
   logic [15:0] mem [icap_pkg::DEPTH];
   wire is_pre4 = mode == icap_pkg::MODE_RISE4;
   wire is_pre = is_pre4 | (mode == icap_pkg::MODE_RISE16);
   wire [3:0] pre_last = is_pre4 ? icap_pkg::PRE4_LAST : icap_pkg::PRE16_LAST;
   always_comb begin
      unique case (mode)
         icap_pkg::MODE_OFF: hit = 1'b0;
         icap_pkg::MODE_BOTH: hit = rise | fall;
         icap_pkg::MODE_FALL: hit = fall;
         icap_pkg::MODE_RISE: hit = rise;
         icap_pkg::MODE_RISE4: hit = rise & (pre == pre_last);
         icap_pkg::MODE_RISE16: hit = rise & (pre == pre_last);
         icap_pkg::MODE_RSVD: hit = 1'b0;
         icap_pkg::MODE_WAKE: hit = rise;
      endcase
   end
   // Sleep and idle with the wake mode: interrupt source only
   wire irq_only = (sleep_i | idle_i) & (mode == icap_pkg::MODE_WAKE);
   wire live = ~sleep_i & ~(idle_i & halt_i);
   wire evt = irq_only ? rise : (hit & live);
   wire full = cnt == icap_pkg::FULL_CNT;
   wire store = evt & ~irq_only & ~ovf_o;
   wire push = store & ~full;
   wire ovf_set = store & full & (mode != icap_pkg::MODE_BOTH);
   wire pop = pop_i & has_data_o;
   wire [1:0] wr_idx = pop ? 2'(cnt - 3'h1) : cnt[1:0];
   wire [2:0] next_cnt = 3'(cnt + {2'h0, push} - {2'h0, pop});
   wire [15:0] stamp = tsel_i ? timer2_i : timer3_i;

   // ==========================================================
   // Prescaler
   always_ff @(posedge mclk_i) begin
      if (reset_i || mode == icap_pkg::MODE_OFF) begin
         pre <= 4'h0;
      end else if (rise && is_pre && live && !irq_only) begin
         pre <= (pre == pre_last) ? 4'h0 : 4'(pre + 4'h1);
      end
   end

   // ==========================================================
   // FIFO, overflow, interrupt count
   always_ff @(posedge mclk_i) begin
      if (pop) begin
         for (int i = 0; i < icap_pkg::DEPTH - 1; i++) begin
            mem[i] <= mem[i + 1];
         end
      end
      if (push) begin
         mem[wr_idx] <= stamp;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         cnt <= 3'h0;
         ovf_o <= 1'b0;
         ev_cnt <= 2'h0;
         irq_set_o <= 1'b0;
      end else begin
         cnt <= next_cnt;
         if (ovf_set) begin
            ovf_o <= 1'b1;
         end else if (pop && next_cnt == 3'h0) begin
            ovf_o <= 1'b0;
         end
         if (mode == icap_pkg::MODE_OFF) begin
            ev_cnt <= 2'h0;
            irq_set_o <= 1'b0;
         end else if (irq_only || mode == icap_pkg::MODE_BOTH) begin
            irq_set_o <= evt;
         end else if (push) begin
            irq_set_o <= ev_cnt == epi_i;
            ev_cnt <= (ev_cnt == epi_i) ? 2'h0 : 2'(ev_cnt + 2'h1);
         end else begin
            irq_set_o <= 1'b0;
         end
      end
   end
   assign head_o = mem[0];
   assign has_data_o = cnt != 3'h0;

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   property p_ovf_full;
      $rose(ovf_o) |-> $past(cnt) == icap_pkg::FULL_CNT;
   endproperty
   a_ovf_full: assert property (p_ovf_full) else $error("overflow without full fifo");

   property p_lock;
      ovf_o && evt && !pop_i |=> cnt == $past(cnt);
   endproperty
   a_lock: assert property (p_lock) else $error("capture stored while locked");

   property p_tsel;
      push && !pop && !tsel_i |=> mem[$past(wr_idx)] == $past(timer3_i);
   endproperty
   a_tsel: assert property (p_tsel) else $error("wrong timer captured");

   property p_both_irq;
      mode == icap_pkg::MODE_BOTH && live && (rise || fall) |=> irq_set_o;
   endproperty
   a_both_irq: assert property (p_both_irq) else $error("edge gave no interrupt");
endmodule : capture_channel

`default_nettype wire

// ===== bench/hall_source.sv
/*
 Behavioural hall sensor that drives the eight capture pins.
 Assumes the bench calls its tasks one at a time from one process.
*/
`timescale 1ns/1ps
`default_nettype none

module hall_source (
   // Clock
   input wire logic mclk_i,
   // Sensor levels, one per channel
   output logic [7:0] pin_o
);
   initial pin_o = 8'h00;

   // ==========================================================
   // Edge generation
   // Each level holds at least 9 cycles: far above the 2-cycle minimum and
   // long enough for the capture and its flag to land
   task drive(input int ch, input logic lvl);
      @(posedge mclk_i);
      pin_o[ch] <= lvl;
      repeat (8) @(posedge mclk_i);
   endtask : drive

   task rise(input int ch, input int n);
      repeat (n) begin
         drive(ch, 1'b1);
         drive(ch, 1'b0);
      end
   endtask : rise
endmodule : hall_source

`default_nettype wire

// ===== bench/tb.sv
/*
 Self-checking bench for the capture unit: Avalon-MM read and write
 tasks and the hall source drive sequences with expected values.
 Assumes the map of the package; timers are held still per capture.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
   // ==========================================================
   // Signals
   logic mclk_i;
   logic reset_i;
   logic [6:0] addr;
   logic rd;
   logic wr;
   logic [31:0] wdata;
   logic [3:0] ben;
   logic [31:0] rdata;
   logic waitreq;
   logic [7:0] pins;
   logic [15:0] timer2;
   logic [15:0] timer3;
   logic sleep;
   logic idle;
   logic [7:0] irq_req;
   logic wake;
   int n_mismatch = 0;
   int checked = 0;
   int wake_cnt = 0;

   input_capture_channels i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .avs_address_i(addr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(ben), .avs_readdata_o(rdata),
      .avs_waitrequest_o(waitreq), .capture_pin_i(pins), .timer2_i(timer2), .timer3_i(timer3),
      .sleep_i(sleep), .idle_i(idle), .channel_irq_req_o(irq_req), .wake_o(wake));
   hall_source i_src (.mclk_i(mclk_i), .pin_o(pins));

   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   // Wake is a one-cycle pulse, so count it instead of polling
   always @(posedge mclk_i) begin
      if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
   end

   // ==========================================================
   // Tasks
   task results;
      $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task bus(input logic is_rd, input logic [6:0] a, input logic [31:0] d, output logic [31:0] q);
      int i;
      @(posedge mclk_i);
      addr <= a;
      rd <= is_rd;
      wr <= !is_rd;
      wdata <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk_i);
         if (waitreq === 1'b0) break;
      end
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (i == 20) begin
         n_mismatch++;
         $display("FAIL bus answer expected 0 seen %h", waitreq);
         results();
      end
   endtask : bus

   task wreg(input logic [6:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b0, a, d, q);
   endtask : wreg

   task rchk(input string name, input logic [6:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b1, a, 32'h0000_0000, q);
      chk(name, exp, q);
   endtask : rchk

   function automatic logic [6:0] ctl(input int ch);
      return 7'(8 * ch + 4);
   endfunction : ctl

   function automatic logic [6:0] fifo(input int ch);
      return 7'(8 * ch);
   endfunction : fifo

   // ==========================================================
   // Sequence
   initial begin
      int k;
      int w;
      reset_i = 1'b1;
      addr = 7'h00;
      rd = 1'b0;
      wr = 1'b0;
      wdata = 32'h0000_0000;
      ben = 4'hF;
      timer2 = 16'h0000;
      timer3 = 16'h0000;
      sleep = 1'b0;
      idle = 1'b0;
      repeat (3) @(posedge mclk_i);
      reset_i <= 1'b0;
      for (k = 0; k < 8; k++) rchk("ctrl reset", ctl(k), 32'h0000_0000);
      rchk("flag reset", icap_pkg::FLAG_ADDR, 32'h0000_0000);
      rchk("enable reset", icap_pkg::EN_ADDR, 32'h0000_0000);
      wreg(7'h48, 32'h0000_FFFF);
      rchk("unmapped", 7'h48, 32'h0000_0000);
      // Fill past full, then check order, lock and release
      wreg(ctl(0), 32'h0000_0003);
      for (k = 0; k < 5; k++) begin
         timer3 <= 16'hC000 + 16'(k);
         timer2 <= 16'h3000 + 16'(k);
         i_src.rise(0, 1);
         if (k == 0) rchk("not empty", ctl(0), 32'h0000_000B);
      end
      rchk("overflow", ctl(0), 32'h0000_001B);
      rchk("fifo head", fifo(0), 32'h0000_C000);
      timer3 <= 16'hC0AA;
      i_src.rise(0, 1);
      for (k = 1; k < 4; k++) rchk("fifo order", fifo(0), 32'h0000_C000 + 32'(k));
      rchk("emptied", ctl(0), 32'h0000_0003);
      timer3 <= 16'hC0BB;
      i_src.rise(0, 1);
      rchk("resumed", fifo(0), 32'h0000_C0BB);
      // Timer select picks the other time base
      wreg(ctl(1), 32'h0000_0083);
      timer3 <= 16'hD000;
      timer2 <= 16'h3456;
      i_src.rise(1, 1);
      rchk("timer select", fifo(1), 32'h0000_3456);
      // Falling edge mode ignores the rising edge
      wreg(ctl(2), 32'h0000_0002);
      timer3 <= 16'h1111;
      i_src.drive(2, 1'b1);
      rchk("no rise capture", ctl(2), 32'h0000_0002);
      timer3 <= 16'h2222;
      i_src.drive(2, 1'b0);
      rchk("fall capture", fifo(2), 32'h0000_2222);
      // Prescaler restarts after the channel is switched off
      wreg(ctl(3), 32'h0000_0004);
      i_src.rise(3, 2);
      wreg(ctl(3), 32'h0000_0000);
      wreg(ctl(3), 32'h0000_0004);
      i_src.rise(3, 3);
      rchk("prescale cleared", ctl(3), 32'h0000_0004);
      i_src.rise(3, 1);
      rchk("every 4th", ctl(3), 32'h0000_000C);
      wreg(ctl(4), 32'h0000_0005);
      i_src.rise(4, 15);
      rchk("before 16th", ctl(4), 32'h0000_0005);
      i_src.rise(4, 1);
      rchk("every 16th", ctl(4), 32'h0000_000D);
      // Every-edge mode: flag per edge, count field ignored, no overflow
      // Channels 0 to 4 have each raised their flag by now
      rchk("capture flags", icap_pkg::FLAG_ADDR, 32'h0000_001F);
      wreg(icap_pkg::FLAG_ADDR, 32'h0000_00FF);
      rchk("flags cleared", icap_pkg::FLAG_ADDR, 32'h0000_0000);
      wreg(icap_pkg::EN_ADDR, 32'h0000_0020);
      wreg(ctl(5), 32'h0000_0061);
      for (k = 0; k < 6; k++) begin
         i_src.drive(5, !k[0]);
         rchk("edge flag", icap_pkg::FLAG_ADDR, 32'h0000_0020);
         chk("irq request", 32'h0000_0020, {24'h00_0000, irq_req});
         wreg(icap_pkg::FLAG_ADDR, 32'h0000_0020);
      end
      rchk("no overflow", ctl(5), 32'h0000_0069);
      // Two captures per interrupt, enable off
      wreg(ctl(6), 32'h0000_0023);
      i_src.rise(6, 1);
      rchk("count 1", icap_pkg::FLAG_ADDR, 32'h0000_0000);
      i_src.rise(6, 1);
      rchk("count 2", icap_pkg::FLAG_ADDR, 32'h0000_0040);
      chk("masked request", 32'h0000_0000, {24'h00_0000, irq_req});
      wreg(icap_pkg::FLAG_ADDR, 32'h0000_0040);
      i_src.rise(7, 2);
      rchk("off no capture", ctl(7), 32'h0000_0000);
      rchk("off no flag", icap_pkg::FLAG_ADDR, 32'h0000_0000);
      // Sleep: interrupt-only channel wakes, others stay quiet
      wreg(icap_pkg::EN_ADDR, 32'h0000_00A0);
      wreg(ctl(7), 32'h0000_0007);
      sleep <= 1'b1;
      w = wake_cnt;
      i_src.rise(7, 1);
      chk("sleep wake", 32'(w + 1), 32'(wake_cnt));
      rchk("sleep no store", ctl(7), 32'h0000_0007);
      i_src.rise(6, 2);
      rchk("sleep flags", icap_pkg::FLAG_ADDR, 32'h0000_0080);
      wreg(icap_pkg::FLAG_ADDR, 32'h0000_00FF);
      sleep <= 1'b0;
      // Idle: full function unless halted, wake mode stores nothing
      idle <= 1'b1;
      w = wake_cnt;
      i_src.rise(7, 1);
      chk("idle wake", 32'(w + 1), 32'(wake_cnt));
      rchk("idle no store", ctl(7), 32'h0000_0007);
      wreg(icap_pkg::FLAG_ADDR, 32'h0000_00FF);
      i_src.rise(6, 2);
      rchk("idle running", icap_pkg::FLAG_ADDR, 32'h0000_0040);
      wreg(icap_pkg::FLAG_ADDR, 32'h0000_00FF);
      wreg(ctl(6), 32'h0000_2023);
      i_src.rise(6, 2);
      rchk("idle halted", icap_pkg::FLAG_ADDR, 32'h0000_0000);
      idle <= 1'b0;
      results();
   end
endmodule : tb

`default_nettype wire
